//--- dsa_access.sv
// Data-space byte/word access: address decode, lane select, strobes, traps
`timescale 1ns/10ps
module dsa_access
    import dsa_pkg::*;
#(
    parameter int RAM_WORDS = 2048
) (
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire logic         REQ_VALID,
    input  wire logic         REQ_WRITE,
    input  wire logic         REQ_BYTE,
    input  wire dsa_mode_type REQ_MODE,
    input  wire logic [15:0]  REQ_PTR,
    input  wire logic [15:0]  REQ_LIT,
    input  wire logic [15:0]  REQ_WDATA,
    input  wire logic         REQ_TO_WREG,
    input  wire logic [15:0]  WREG_OLD,
    input  wire logic         EXT_VALID,
    input  wire logic         EXT_SIGN,
    input  wire logic [15:0]  SFR_RDATA,
    input  wire logic         SFR_ACK,
    input  wire logic         TRAP_ACK,
    output logic              RD_VALID,
    output logic [15:0]       RD_DATA,
    output logic              PTR_WE,
    output logic [15:0]       PTR_NEXT,
    output logic              WREG_WE,
    output logic [15:0]       WREG_RESULT,
    output logic              TRAP_REQ,
    output logic [15:0]       FAULT_ADDR,
    output logic              FAULT_WRITE,
    output logic              SFR_WE_LO,
    output logic              SFR_WE_HI,
    output logic [15:0]       SFR_ADDR,
    output logic [15:0]       SFR_WDATA,
    output logic              SFR_SEL,
    output logic              NEAR_SEL,
    output logic              PSW_SEL
);

    localparam int          AW      = $clog2(RAM_WORDS);
    localparam logic [16:0] RAM_END = 17'(RAM_BASE) + 17'(2 * RAM_WORDS);

    dsa_state_type state_q;
    dsa_state_type state_d;

    logic [15:0]   effective_addr;
    logic          mem_space;
    logic          sfr_hit;
    logic          ram_hit;
    logic          misalign;
    logic          trap_set;
    logic          rd_req;
    logic          wr_ok;
    logic [15:0]   ram_off;
    logic [AW-1:0] ram_idx;
    logic          we_lo;
    logic          we_hi;
    logic [7:0]    wdata_lo;
    logic [7:0]    wdata_hi;
    logic [7:0]    rdata_lo;
    logic [7:0]    rdata_hi;
    logic [15:0]   word_rd;
    logic [15:0]   path_rd;
    logic          wreg_load;
    logic          ext_go;
    logic [15:0]   wreg_val;

    ////////////////////////////////////////////////////////////////////////
    // Effective address forming and region decode

    // Direct 13-bit field only reaches the near region by construction
    always_comb begin
        case (REQ_MODE)
            MODE_DIR13: effective_addr = {3'h0, REQ_LIT[DIR13_W-1:0]};
            MODE_DIR16: effective_addr = REQ_LIT;
            MODE_IND:   effective_addr = REQ_PTR;
            default:    effective_addr = REQ_PTR;
        endcase
    end

    // Upper half is the program space window, never implemented memory
    assign mem_space = !effective_addr[PSW_BIT];
    assign sfr_hit   = mem_space && (effective_addr <= SFR_LAST);
    assign ram_hit   = mem_space && (effective_addr >= RAM_BASE)
                       && ({1'b0, effective_addr} < RAM_END);
    assign ram_off   = effective_addr - RAM_BASE;
    assign ram_idx   = ram_off[AW:1]; // Shared word decode for both lanes

    // Bytes are never checked; word at odd address is the only fault
    assign misalign  = !REQ_BYTE && effective_addr[0];
    assign trap_set  = REQ_VALID && misalign;
    assign rd_req    = REQ_VALID && !REQ_WRITE;
    assign wr_ok     = REQ_VALID && REQ_WRITE && !misalign;

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes with separate write strobes

    // A byte write lands on one side only; the other byte keeps its value
    assign we_lo    = wr_ok && ram_hit && (!REQ_BYTE || !effective_addr[0]);
    assign we_hi    = wr_ok && ram_hit && (!REQ_BYTE || effective_addr[0]);
    assign wdata_lo = REQ_WDATA[7:0];
    assign wdata_hi = REQ_BYTE ? REQ_WDATA[7:0] : REQ_WDATA[15:8];

    dsa_byte_lane #(
        .DEPTH (RAM_WORDS),
        .AW    (AW)
    ) u_lane_lo (
        .clk   (CLK),
        .we    (we_lo),
        .idx   (ram_idx),
        .wdata (wdata_lo),
        .rdata (rdata_lo)
    );

    dsa_byte_lane #(
        .DEPTH (RAM_WORDS),
        .AW    (AW)
    ) u_lane_hi (
        .clk   (CLK),
        .we    (we_hi),
        .idx   (ram_idx),
        .wdata (wdata_hi),
        .rdata (rdata_hi)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data path

    // Unclaimed special addresses, holes and the window all read zero
    always_comb begin
        if (ram_hit) begin
            word_rd = {rdata_hi, rdata_lo};
        end else if (sfr_hit && SFR_ACK) begin
            word_rd = SFR_RDATA;
        end else begin
            word_rd = RST_WORD;
        end
    end

    // Whole word is fetched, then the addressed byte goes to the low side
    assign path_rd = REQ_BYTE ? {ZERO_BYTE, (effective_addr[0] ? word_rd[15:8]
                                                : word_rd[7:0])} : word_rd;

    ////////////////////////////////////////////////////////////////////////
    // Working register result

    // A load into a working register takes priority over an extension
    assign wreg_load = rd_req && REQ_TO_WREG;
    assign ext_go    = EXT_VALID && !wreg_load;

    dsa_wreg_merge u_merge (
        .sel_ext  (ext_go),
        .ext_sign (EXT_SIGN),
        .is_byte  (REQ_BYTE),
        .rdata    (path_rd),
        .old      (WREG_OLD),
        .result   (wreg_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_d           = state_q;
        // A misaligned read still returns its data
        state_d.rd_valid  = rd_req;
        state_d.rd_data   = rd_req ? path_rd : state_q.rd_data;
        state_d.ptr_we    = REQ_VALID && (REQ_MODE == MODE_IND_POSTINC);
        state_d.ptr_next  = REQ_PTR + (REQ_BYTE ? PTR_STEP_BYTE : PTR_STEP_WORD);
        state_d.wreg_we   = wreg_load || ext_go;
        state_d.wreg_res  = wreg_val;
        // Store to special registers goes out a cycle late, registered
        state_d.sfr_we_lo = wr_ok && sfr_hit && (!REQ_BYTE || !effective_addr[0]);
        state_d.sfr_we_hi = wr_ok && sfr_hit && (!REQ_BYTE || effective_addr[0]);
        state_d.sfr_addr  = REQ_VALID ? effective_addr : state_q.sfr_addr;
        state_d.sfr_wdata = REQ_VALID ? {wdata_hi, wdata_lo} : state_q.sfr_wdata;
        state_d.sfr_sel   = REQ_VALID && sfr_hit;
        state_d.near_sel  = REQ_VALID && mem_space && (effective_addr <= NEAR_LAST);
        state_d.psw_sel   = REQ_VALID && !mem_space;
        // New fault wins over the core's acknowledge in the same cycle
        state_d.trap      = trap_set || (state_q.trap && !TRAP_ACK);
        if (trap_set) begin
            state_d.fault_addr = effective_addr;
            state_d.fault_wr   = REQ_WRITE;
        end
    end

    // Single register stage for all state
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register

    assign RD_VALID    = state_q.rd_valid;
    assign RD_DATA     = state_q.rd_data;
    assign PTR_WE      = state_q.ptr_we;
    assign PTR_NEXT    = state_q.ptr_next;
    assign WREG_WE     = state_q.wreg_we;
    assign WREG_RESULT = state_q.wreg_res;
    assign TRAP_REQ    = state_q.trap;
    assign FAULT_ADDR  = state_q.fault_addr;
    assign FAULT_WRITE = state_q.fault_wr;
    assign SFR_WE_LO   = state_q.sfr_we_lo;
    assign SFR_WE_HI   = state_q.sfr_we_hi;
    assign SFR_ADDR    = state_q.sfr_addr;
    assign SFR_WDATA   = state_q.sfr_wdata;
    assign SFR_SEL     = state_q.sfr_sel;
    assign NEAR_SEL    = state_q.near_sel;
    assign PSW_SEL     = state_q.psw_sel;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_ptr_step: assert property (
        REQ_VALID && REQ_MODE == MODE_IND_POSTINC |=> PTR_WE
            && PTR_NEXT == $past(REQ_PTR) + ($past(REQ_BYTE) ? 16'h0001 : 16'h0002))
        else $error("pointer step wrong");

    a_byte_rd_low: assert property (
        rd_req && REQ_BYTE |=> RD_VALID && RD_DATA[15:8] == 8'h00)
        else $error("byte read not on low byte");

    a_byte_wr_lane: assert property (
        REQ_VALID && REQ_WRITE && REQ_BYTE && ram_hit
            |-> we_lo != we_hi && we_hi == effective_addr[0])
        else $error("byte write strobes wrong lane");

    a_odd_word_trap: assert property (
        REQ_VALID && !REQ_BYTE && effective_addr[0]
            |=> TRAP_REQ && FAULT_ADDR == $past(effective_addr))
        else $error("misaligned word did not trap");

    a_bad_rd_done: assert property (
        rd_req && misalign |=> RD_VALID && TRAP_REQ)
        else $error("misaligned read not completed");

    a_bad_wr_drop: assert property (
        REQ_VALID && REQ_WRITE && misalign
            |-> !we_lo && !we_hi ##1 !SFR_WE_LO && !SFR_WE_HI && FAULT_WRITE)
        else $error("misaligned write not suppressed");

    a_trap_holds: assert property (
        TRAP_REQ && !TRAP_ACK |=> TRAP_REQ)
        else $error("trap dropped before acknowledge");

    a_byte_load_hi: assert property (
        wreg_load && REQ_BYTE |=> WREG_WE && WREG_RESULT[15:8] == $past(WREG_OLD[15:8]))
        else $error("byte load touched high byte");

    a_sign_extend: assert property (
        ext_go && EXT_SIGN |=> WREG_RESULT == {{8{$past(WREG_OLD[7])}}, $past(WREG_OLD[7:0])})
        else $error("sign extension wrong");

    a_zero_extend: assert property (
        ext_go && !EXT_SIGN |=> WREG_RESULT == {8'h00, $past(WREG_OLD[7:0])})
        else $error("zero extension wrong");

    a_sfr_unused_zero: assert property (
        rd_req && sfr_hit && !SFR_ACK |=> RD_DATA == 16'h0000)
        else $error("unused special address not zero");

    a_beyond_zero: assert property (
        rd_req && !ram_hit && !sfr_hit |=> RD_DATA == 16'h0000 && PSW_SEL == $past(!mem_space))
        else $error("unimplemented address not zero");

    a_byte_no_trap: assert property (
        REQ_VALID && REQ_BYTE && !TRAP_REQ && !state_q.trap |=> !$rose(TRAP_REQ))
        else $error("byte access trapped");

    c_byte_read:  cover property (rd_req && REQ_BYTE && ram_hit ##1 RD_VALID);
    c_word_write: cover property (wr_ok && !REQ_BYTE && ram_hit);
    c_trap_ack:   cover property (trap_set ##1 TRAP_REQ ##[1:4] TRAP_ACK);
    c_post_inc:   cover property (REQ_VALID && REQ_MODE == MODE_IND_POSTINC ##1 PTR_WE);

endmodule : dsa_access

//--- dsa_pkg.sv
// Shared constants and types for the data-space byte/word access block
package dsa_pkg;

    // Region limits of the data space
    localparam logic [15:0] SFR_LAST      = 16'h0FFF;
    localparam logic [15:0] NEAR_LAST     = 16'h1FFF;
    localparam logic [15:0] RAM_BASE      = 16'h1000;
    localparam int          PSW_BIT       = 15;
    localparam int          DIR13_W       = 13;

    // Pointer post-modify steps
    localparam logic [15:0] PTR_STEP_BYTE = 16'h0001;
    localparam logic [15:0] PTR_STEP_WORD = 16'h0002;

    // Values after reset and fill values
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam logic [7:0]  ONES_BYTE     = 8'hFF;

    // Ways in which the core forms the effective address
    typedef enum logic [1:0] {
        MODE_IND,
        MODE_IND_POSTINC,
        MODE_DIR13,
        MODE_DIR16
    } dsa_mode_type;

    // Complete registered state of the access block
    typedef struct packed {
        logic [15:0] rd_data;
        logic        rd_valid;
        logic [15:0] ptr_next;
        logic        ptr_we;
        logic [15:0] wreg_res;
        logic        wreg_we;
        logic        trap;
        logic [15:0] fault_addr;
        logic        fault_wr;
        logic        sfr_we_lo;
        logic        sfr_we_hi;
        logic [15:0] sfr_addr;
        logic [15:0] sfr_wdata;
        logic        sfr_sel;
        logic        near_sel;
        logic        psw_sel;
    } dsa_state_type;

endpackage : dsa_pkg

//--- dsa_byte_lane.sv
// One byte-wide lane of the data memory, word-indexed
`timescale 1ns/10ps
module dsa_byte_lane #(
    parameter int DEPTH = 2048,
    parameter int AW    = 11
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] idx,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);

    logic [7:0] mem [DEPTH];

    // Write on the edge; only this lane's strobe touches this lane
    always_ff @(posedge clk) begin
        if (we) begin
            mem[idx] <= wdata;
        end
    end

    // Read is asynchronous so the access finishes in one cycle
    assign rdata = mem[idx];

endmodule : dsa_byte_lane

//--- dsa_wreg_merge.sv
// Working register result: byte/word load merge and sign or zero extension
`timescale 1ns/10ps
module dsa_wreg_merge
    import dsa_pkg::*;
(
    input  wire logic        sel_ext,
    input  wire logic        ext_sign,
    input  wire logic        is_byte,
    input  wire logic [15:0] rdata,
    input  wire logic [15:0] old,
    output logic      [15:0] result
);

    // Extension works on the register itself; loads work on read data
    always_comb begin
        if (sel_ext && ext_sign) begin
            result = {(old[7] ? ONES_BYTE : ZERO_BYTE), old[7:0]};
        end else if (sel_ext) begin
            result = {ZERO_BYTE, old[7:0]};
        end else if (is_byte) begin
            result = {old[15:8], rdata[7:0]}; // High byte kept untouched
        end else begin
            result = rdata;
        end
    end

endmodule : dsa_wreg_merge

//--- dsa_sfr_model.sv
// Peripheral register model answering the special register region
`timescale 1ns/10ps
module dsa_sfr_model
    import dsa_pkg::*;
#(
    parameter logic [15:0] REG_ADDR = 16'h0C40
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] sfr_addr,
    input  wire logic        we_lo,
    input  wire logic        we_hi,
    input  wire logic [15:0] wdata,
    output logic             ack,
    output logic [15:0]      rdata
);
    logic [15:0] reg_q;
    logic        hit_w;

    ////////////////////////////////////////////////////////////////////////////
    // Claim only our own word; elsewhere drive junk so a leak shows up
    assign ack   = req && (addr[15:1] == REG_ADDR[15:1]);
    assign rdata = ack ? reg_q : ~reg_q;
    assign hit_w = (sfr_addr[15:1] == REG_ADDR[15:1]);

    ////////////////////////////////////////////////////////////////////////////
    // Lane strobes write their own byte only
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_q <= 16'h0000;
        end else begin
            if (we_lo && hit_w) reg_q[7:0] <= wdata[7:0];
            if (we_hi && hit_w) reg_q[15:8] <= wdata[15:8];
        end
    end
endmodule : dsa_sfr_model

//--- test_data_space_byte_word_access.sv
// Self-checking testbench of the data-space byte/word access block
`timescale 1ns/10ps
module test_data_space_byte_word_access;
    import dsa_pkg::*;

    logic         clk = 1'b0, sys_rst = 1'b1;
    logic         req_valid = 1'b0, req_write = 1'b0, req_byte = 1'b0, req_to_wreg = 1'b0;
    logic         ext_valid = 1'b0, ext_sign = 1'b0, trap_ack = 1'b0, sfr_ack;
    dsa_mode_type req_mode = MODE_DIR16;
    logic [15:0]  req_addr = 16'h0000, req_wdata = 16'h0000, wreg_old = 16'h0000;
    logic [15:0]  eff_addr = 16'h0000, sfr_rdata;
    logic         rd_valid, ptr_we, wreg_we, trap_req, fault_write;
    logic         sfr_we_lo, sfr_we_hi, sfr_sel, near_sel, psw_sel;
    logic [15:0]  rd_data, ptr_next, wreg_result, fault_addr, sfr_addr, sfr_wdata;
    int           err_count = 0, n_checks = 0;

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Block under test with a small RAM so the out-of-range area is easy to hit
    dsa_access #(.RAM_WORDS(16)) i_dut (
        .CLK(clk), .SYS_RST(sys_rst), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_BYTE(req_byte), .REQ_MODE(req_mode), .REQ_PTR(req_addr), .REQ_LIT(req_addr),
        .REQ_WDATA(req_wdata), .REQ_TO_WREG(req_to_wreg), .WREG_OLD(wreg_old),
        .EXT_VALID(ext_valid), .EXT_SIGN(ext_sign), .SFR_RDATA(sfr_rdata),
        .SFR_ACK(sfr_ack), .TRAP_ACK(trap_ack), .RD_VALID(rd_valid), .RD_DATA(rd_data),
        .PTR_WE(ptr_we), .PTR_NEXT(ptr_next), .WREG_WE(wreg_we),
        .WREG_RESULT(wreg_result), .TRAP_REQ(trap_req), .FAULT_ADDR(fault_addr),
        .FAULT_WRITE(fault_write), .SFR_WE_LO(sfr_we_lo), .SFR_WE_HI(sfr_we_hi),
        .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_SEL(sfr_sel),
        .NEAR_SEL(near_sel), .PSW_SEL(psw_sel));

    dsa_sfr_model i_sfr (
        .clk(clk), .rst(sys_rst), .req(req_valid), .addr(eff_addr), .sfr_addr(sfr_addr),
        .we_lo(sfr_we_lo), .we_hi(sfr_we_hi), .wdata(sfr_wdata), .ack(sfr_ack),
        .rdata(sfr_rdata));

    ////////////////////////////////////////////////////////////////////////////
    // Shared compare, verdict and bus tasks
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    // One-cycle request with an idle cycle before it; returns where answers stand
    task automatic acc(input logic wr, input logic by, input dsa_mode_type md,
                       input logic [15:0] a, input logic [15:0] wd,
                       input logic tw, input logic [15:0] old);
        @(posedge clk);
        #1;
        req_valid = 1'b1; req_write = wr; req_byte = by; req_mode = md;
        req_addr = a; req_wdata = wd; req_to_wreg = tw; wreg_old = old;
        eff_addr = (md == MODE_DIR13) ? {3'b000, a[12:0]} : a;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask : acc

    task automatic ack_trap();
        @(posedge clk);
        #1 trap_ack = 1'b1;
        @(posedge clk);
        #1 trap_ack = 1'b0;
        chk("trap cleared", trap_req, 16'h0000);
    endtask : ack_trap

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_lanes();
        acc(1, 0, MODE_DIR16, 16'h1002, 16'hA55A, 0, 16'h0000);
        acc(1, 1, MODE_IND, 16'h1003, 16'h003C, 0, 16'h0000);
        acc(0, 0, MODE_IND, 16'h1002, 16'h0000, 0, 16'h0000);
        chk("word read", rd_data, 16'h3C5A);
        chk("read valid", rd_valid, 16'h0001);
        acc(0, 1, MODE_DIR16, 16'h1003, 16'h0000, 0, 16'h0000);
        chk("byte read hi", rd_data, 16'h003C);
        acc(0, 1, MODE_IND, 16'h1002, 16'h0000, 1, 16'hBEEF);
        chk("wreg we", wreg_we, 16'h0001);
        chk("byte load", wreg_result, 16'hBE5A);
        acc(0, 0, MODE_IND, 16'h1002, 16'h0000, 1, 16'hBEEF);
        chk("word load we", wreg_we, 16'h0001);
        chk("word load", wreg_result, 16'h3C5A);
    endtask : t_lanes

    task automatic t_postinc();
        acc(0, 1, MODE_IND_POSTINC, 16'h1004, 16'h0000, 0, 16'h0000);
        chk("ptr we byte", ptr_we, 16'h0001);
        chk("ptr byte", ptr_next, 16'h1005);
        acc(1, 0, MODE_IND_POSTINC, 16'h1006, 16'h0000, 0, 16'h0000);
        chk("ptr word", ptr_next, 16'h1008);
        acc(0, 0, MODE_IND, 16'h1004, 16'h0000, 0, 16'h0000);
        chk("no ptr we", ptr_we, 16'h0000);
    endtask : t_postinc

    task automatic t_misaligned();
        acc(1, 0, MODE_DIR16, 16'h1004, 16'h1234, 0, 16'h0000);
        acc(1, 0, MODE_DIR16, 16'h1005, 16'hFFFF, 0, 16'h0000);
        chk("trap on write", trap_req, 16'h0001);
        chk("fault addr w", fault_addr, 16'h1005);
        chk("fault write", fault_write, 16'h0001);
        ack_trap();
        acc(0, 0, MODE_DIR16, 16'h1004, 16'h0000, 0, 16'h0000);
        chk("write dropped", rd_data, 16'h1234);
        acc(1, 0, MODE_DIR16, 16'h0C43, 16'hFFFF, 0, 16'h0000);
        chk("no strobes", {sfr_we_hi, sfr_we_lo}, 16'h0000);
        ack_trap();
        acc(0, 0, MODE_IND, 16'h1005, 16'h0000, 0, 16'h0000);
        chk("odd read done", rd_valid, 16'h0001);
        chk("odd read data", rd_data, 16'h1234);
        chk("trap on read", trap_req, 16'h0001);
        chk("fault read", fault_write, 16'h0000);
        ack_trap();
        acc(0, 1, MODE_IND, 16'h1005, 16'h0000, 0, 16'h0000);
        chk("byte no trap", trap_req, 16'h0000);
        chk("odd byte", rd_data, 16'h0012);
    endtask : t_misaligned

    task automatic t_extend();
        logic [15:0] olds [3] = '{16'h1280, 16'h127F, 16'hAB80};
        logic [15:0] exps [3] = '{16'hFF80, 16'h007F, 16'h0080};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            #1;
            ext_valid = 1'b1; ext_sign = (i < 2); wreg_old = olds[i];
            @(posedge clk);
            #1 ext_valid = 1'b0;
            chk("ext we", wreg_we, 16'h0001);
            chk("ext result", wreg_result, exps[i]);
        end
    endtask : t_extend

    task automatic t_sfr();
        acc(1, 0, MODE_DIR16, 16'h0C40, 16'h1357, 0, 16'h0000);
        chk("word strobes", {sfr_we_hi, sfr_we_lo}, 16'h0003);
        chk("sfr sel", sfr_sel, 16'h0001);
        acc(1, 1, MODE_IND, 16'h0C41, 16'h009A, 0, 16'h0000);
        chk("hi strobe", {sfr_we_hi, sfr_we_lo}, 16'h0002);
        chk("lane data", sfr_wdata, 16'h9A9A);
        acc(0, 0, MODE_DIR13, 16'h0C40, 16'h0000, 0, 16'h0000);
        chk("sfr read", rd_data, 16'h9A57);
        acc(0, 0, MODE_DIR16, 16'h0C80, 16'h0000, 0, 16'h0000);
        chk("unused sfr", rd_data, 16'h0000);
        acc(0, 1, MODE_DIR16, 16'h0FFF, 16'h0000, 0, 16'h0000);
        chk("sfr top", sfr_sel, 16'h0001);
        acc(0, 1, MODE_DIR16, 16'h1000, 16'h0000, 0, 16'h0000);
        chk("ram not sfr", {sfr_sel, near_sel}, 16'h0001);
    endtask : t_sfr

    task automatic t_regions();
        acc(0, 0, MODE_DIR13, 16'hFC40, 16'h0000, 0, 16'h0000);
        chk("near addr", sfr_addr, 16'h1C40);
        chk("near sel", near_sel, 16'h0001);
        chk("beyond ram", rd_data, 16'h0000);
        acc(0, 0, MODE_DIR16, 16'h1002, 16'h0000, 0, 16'h0000);
        acc(0, 0, MODE_DIR16, 16'h2000, 16'h0000, 0, 16'h0000);
        chk("far sel", {near_sel, psw_sel}, 16'h0000);
        chk("far zero", rd_data, 16'h0000);
        acc(0, 0, MODE_IND, 16'h1002, 16'h0000, 0, 16'h0000);
        acc(0, 0, MODE_IND, 16'h9002, 16'h0000, 0, 16'h0000);
        chk("window sel", psw_sel, 16'h0001);
        chk("window zero", rd_data, 16'h0000);
    endtask : t_regions

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog, both ending through summarize
    initial begin
        repeat (12) @(posedge clk);
        #1 sys_rst = 1'b0;
        chk("trap after reset", trap_req, 16'h0000);
        t_lanes();
        t_postinc();
        t_misaligned();
        t_extend();
        t_sfr();
        t_regions();
        summarize();
    end

    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule : test_data_space_byte_word_access
